// File: hw/nvram_host_pkg.sv
// constants and types for the nonvolatile sram host controller
package nvram_host_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // access, setup and pulse times in ns, completion waits in ms and us
  localparam int ACCESS_NS = 45;
  localparam int WRITE_PULSE_NS = 30;
  localparam int SAVE_INIT_NS = 20;
  localparam int RELOAD_INIT_NS = 20;
  localparam int SAVE_MAX_MS = 10;
  localparam int RELOAD_MAX_US = 20;
  localparam int POWER_UP_RELOAD_US = 550;
  // least times round up, waits for completion are maximum figures
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAVE_INIT_CYC =
    (SAVE_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELOAD_INIT_CYC =
    (RELOAD_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAVE_CYC = SAVE_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RELOAD_CYC = RELOAD_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int POWER_UP_CYC = POWER_UP_RELOAD_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  // request codes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SAVE = 2'h2;
  localparam logic [1:0] OP_RELOAD = 2'h3;
  typedef enum logic [2:0] {
    ST_POWER_UP = 3'h0,
    ST_IDLE = 3'h1,
    ST_ACTIVE = 3'h3,
    ST_WAIT = 3'h2,
    ST_RECOVER = 3'h6
  } state_t;
endpackage

// File: hw/nvram_host.sv
// host controller driving the nonvolatile sram control pins
`timescale 1ns/1ps
module nvram_host #(
  parameter int POWER_UP_CYC = nvram_host_pkg::POWER_UP_CYC,
  parameter int SAVE_CYC = nvram_host_pkg::SAVE_CYC,
  parameter int RELOAD_CYC = nvram_host_pkg::RELOAD_CYC
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic req_valid_i, // request present
  input wire logic [1:0] req_op_i, // request code
  input wire logic [nvram_host_pkg::ADDR_W-1:0] req_addr_i, // address
  input wire logic [nvram_host_pkg::DATA_W-1:0] req_wdata_i, // write data
  output logic req_ready_o, // high in idle; a valid request is taken this cycle
  output logic done_o, // one-cycle completion pulse
  output logic [nvram_host_pkg::DATA_W-1:0] rdata_o, // read data
  output logic chip_select_n_o, // chip select pin
  output logic write_strobe_n_o, // write strobe pin
  output logic output_gate_n_o, // output gate pin
  output logic nonvolatile_select_n_o, // nonvolatile select pin
  output logic [nvram_host_pkg::ADDR_W-1:0] addr_o, // address pins
  input wire logic [nvram_host_pkg::DATA_W-1:0] data_lines_i, // data in
  output logic [nvram_host_pkg::DATA_W-1:0] data_lines_o, // data out
  output logic data_lines_oe_o // high while host drives data
);
  localparam int CW = nvram_host_pkg::CNT_W;

  nvram_host_pkg::state_t state, next_state;
  logic [1:0] op, next_op;
  logic [CW-1:0] cnt, next_cnt;
  logic [nvram_host_pkg::ADDR_W-1:0] next_addr;
  logic [nvram_host_pkg::DATA_W-1:0] wdata, next_wdata;
  logic [nvram_host_pkg::DATA_W-1:0] next_rdata;
  logic next_done;
  // strobes from the sequencer to the data group
  logic take_req; // request accepted at this edge
  logic read_end; // access time met, read data valid
  logic op_end; // operation finished
  // next pin levels; registered so decode glitches never reach the pins
  logic next_cs_n, next_we_n, next_gate_n, next_nv_n, next_oe;

  // cycle count for a timing constant
  function automatic logic [CW-1:0] cyc(input int n);
    return CW'(n - 1);
  endfunction

  // pin levels for the coming cycle, decoded from the next state
  // a strobe glitch would start a stray write, save or reload
  always_comb begin
    next_cs_n = 1'h1;
    next_we_n = 1'h1;
    next_gate_n = 1'h1;
    next_nv_n = 1'h1;
    next_oe = 1'h0;
    if (next_state == nvram_host_pkg::ST_ACTIVE) begin
      next_cs_n = 1'h0;
      unique case (next_op)
        nvram_host_pkg::OP_READ: begin
          next_gate_n = 1'h0;
        end
        nvram_host_pkg::OP_WRITE: begin
          // strobe falls with select, so the device keeps its outputs off
          next_we_n = 1'h0;
          next_oe = 1'h1;
        end
        nvram_host_pkg::OP_SAVE: begin
          // gate stays high from the first cycle of the save state
          next_we_n = 1'h0;
          next_nv_n = 1'h0;
        end
        nvram_host_pkg::OP_RELOAD: begin
          next_gate_n = 1'h0;
          next_nv_n = 1'h0;
        end
      endcase
    end
  end

  assign req_ready_o = (state == nvram_host_pkg::ST_IDLE);
  assign data_lines_o = wdata;

  // sequencing of requests and long waits
  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    take_req = 1'h0;
    read_end = 1'h0;
    op_end = 1'h0;
    unique case (state)
      nvram_host_pkg::ST_POWER_UP: begin
        // wait out the automatic power-up reload
        if (cnt == '0) begin
          next_state = nvram_host_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      nvram_host_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          take_req = 1'h1;
          next_op = req_op_i;
          next_state = nvram_host_pkg::ST_ACTIVE;
          unique case (req_op_i)
            nvram_host_pkg::OP_READ:
              next_cnt = cyc(nvram_host_pkg::ACCESS_CYC);
            nvram_host_pkg::OP_WRITE:
              next_cnt = cyc(nvram_host_pkg::WRITE_CYC);
            nvram_host_pkg::OP_SAVE:
              next_cnt = cyc(nvram_host_pkg::SAVE_INIT_CYC);
            nvram_host_pkg::OP_RELOAD:
              next_cnt = cyc(nvram_host_pkg::RELOAD_INIT_CYC);
          endcase
        end
      end
      nvram_host_pkg::ST_ACTIVE: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (op == nvram_host_pkg::OP_READ) begin
          read_end = 1'h1;
          op_end = 1'h1;
          next_state = nvram_host_pkg::ST_RECOVER;
        end else if (op == nvram_host_pkg::OP_WRITE) begin
          // select and strobe rise together; address and data still stand
          op_end = 1'h1;
          next_state = nvram_host_pkg::ST_RECOVER;
        end else begin
          // initiation held long enough; release pins and wait
          next_state = nvram_host_pkg::ST_WAIT;
          next_cnt = (op == nvram_host_pkg::OP_SAVE) ?
            cyc(SAVE_CYC) : cyc(RELOAD_CYC);
        end
      end
      nvram_host_pkg::ST_WAIT: begin
        // device busy with save or reload, pins left deselected
        if (cnt == '0) begin
          op_end = 1'h1;
          next_state = nvram_host_pkg::ST_RECOVER;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      nvram_host_pkg::ST_RECOVER: begin
        // one deselected cycle, then idle, so two or more between accesses
        next_state = nvram_host_pkg::ST_IDLE;
      end
      default: begin
        next_state = nvram_host_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer registers; reset restarts the power-up wait
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= nvram_host_pkg::ST_POWER_UP;
      op <= nvram_host_pkg::OP_READ;
      cnt <= CW'(POWER_UP_CYC - 1);
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
    end
  end

  // request capture and answer values
  always_comb begin
    next_addr = addr_o;
    next_wdata = wdata;
    next_rdata = rdata_o;
    next_done = op_end;
    // address and data stay put until the next request is taken
    if (take_req) begin
      next_addr = req_addr_i;
      next_wdata = req_wdata_i;
    end
    // sample in the last selected cycle, before the gate rises
    if (read_end) begin
      next_rdata = data_lines_i;
    end
  end

  // request and answer registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o <= '0;
      wdata <= '0;
      rdata_o <= '0;
      done_o <= 1'h0;
    end else begin
      addr_o <= next_addr;
      wdata <= next_wdata;
      rdata_o <= next_rdata;
      done_o <= next_done;
    end
  end

  // pin registers; strobes and selects high, data_lines_oe_o low, keep the device deselected through reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chip_select_n_o <= 1'h1;
      write_strobe_n_o <= 1'h1;
      output_gate_n_o <= 1'h1;
      nonvolatile_select_n_o <= 1'h1;
      data_lines_oe_o <= 1'h0;
    end else begin
      chip_select_n_o <= next_cs_n;
      write_strobe_n_o <= next_we_n;
      output_gate_n_o <= next_gate_n;
      nonvolatile_select_n_o <= next_nv_n;
      data_lines_oe_o <= next_oe;
    end
  end
endmodule

// File: bench/nvram_host_assertions.sv
// pin protocol checks for the host controller
`timescale 1ns/1ps
module nvram_host_assertions (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic chip_select_n_o, // pin
  input wire logic write_strobe_n_o, // pin
  input wire logic output_gate_n_o, // pin
  input wire logic nonvolatile_select_n_o, // pin
  input wire logic data_lines_oe_o // host drives data
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // entry into a nonvolatile cycle
  sequence nv_entry;
    $fell(nonvolatile_select_n_o);
  endsequence
  sequence save_entry;
    nv_entry ##0 !write_strobe_n_o;
  endsequence
  chk_read_strobe_high: assert property (
    !output_gate_n_o |-> write_strobe_n_o)
    else $error("write strobe low with gate low");
  chk_write_pins: assert property (
    !write_strobe_n_o && data_lines_oe_o |->
    !chip_select_n_o && nonvolatile_select_n_o)
    else $error("bad pins while writing");
  chk_nv_mid_cycle: assert property (
    nv_entry |-> $fell(chip_select_n_o))
    else $error("nonvolatile select fell inside a cycle");
  chk_save_end: assert property (
    save_entry |=> !nonvolatile_select_n_o ##1
    nonvolatile_select_n_o && write_strobe_n_o && chip_select_n_o)
    else $error("save initiation length wrong");
  chk_save_gate: assert property (
    save_entry |-> output_gate_n_o)
    else $error("gate low at save start");
endmodule
bind nvram_host nvram_host_assertions nvram_host_assertions_inst (.clk_i,
  .rst_n_i, .chip_select_n_o, .write_strobe_n_o, .output_gate_n_o,
  .nonvolatile_select_n_o, .data_lines_oe_o);

// File: bench/nvram_model.sv
// behavioural nonvolatile sram device
`timescale 1ns/1ps
module nvram_model (
  input wire logic clk_i, // clock
  input wire logic cs_n_i, // chip select
  input wire logic we_n_i, // write strobe
  input wire logic gate_n_i, // output gate
  input wire logic nv_n_i, // nonvolatile select
  input wire logic [10:0] addr_i, // address
  input wire logic [7:0] din_i, // data wire
  output logic [7:0] dout_o // device data
);
  logic [7:0] sram [2048];
  logic [7:0] nvm [2048];
  logic [7:0] last = 8'h00;
  int busy = 40; // power-up reload
  int hold = 0;
  logic supply_ok = 1'h1; // supply above the save threshold
  logic rd;
  // drive only in idle read state, else inverse of last value
  assign rd = busy == 0 && !cs_n_i && !gate_n_i && we_n_i && nv_n_i;
  assign dout_o = rd ? sram[addr_i] : ~last;
  // writes, save and reload
  always @(posedge clk_i) begin
    if (rd) last <= sram[addr_i];
    hold <= (!cs_n_i && !we_n_i && !nv_n_i && gate_n_i) ? hold + 1 : 0;
    if (busy > 0) busy <= busy - 1;
    else if (hold == 1 && supply_ok) begin
      nvm <= sram;
      busy <= 8;
    end else if (!cs_n_i && !we_n_i && nv_n_i) sram[addr_i] <= din_i;
    else if (!cs_n_i && we_n_i && !gate_n_i && !nv_n_i) begin
      sram <= nvm;
      busy <= 8;
    end
  end
endmodule

// File: bench/nvram_host_tb_top.sv
// self-checking bench for the host controller
`timescale 1ns/1ps
module nvram_host_tb_top;
  logic clk_i = 0, rst_n_i = 0, req_valid_i = 0;
  logic [1:0] req_op_i = 2'h0;
  logic [10:0] req_addr_i = 11'h000, addr_o;
  logic [7:0] req_wdata_i = 8'h00, rdata_o, data_lines_o, dev_q, bus;
  logic req_ready_o, done_o, cs_n, we_n, gate_n, nv_n, oe;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  assign bus = oe ? data_lines_o : dev_q; // shared data wire
  always #5 clk_i = ~clk_i;
  nvram_host #(.POWER_UP_CYC(30), .SAVE_CYC(10), .RELOAD_CYC(10))
    nvram_host_inst (.clk_i, .rst_n_i, .req_valid_i, .req_op_i, .req_addr_i,
    .req_wdata_i, .req_ready_o, .done_o, .rdata_o, .chip_select_n_o(cs_n),
    .write_strobe_n_o(we_n), .output_gate_n_o(gate_n),
    .nonvolatile_select_n_o(nv_n), .addr_o, .data_lines_i(bus),
    .data_lines_o, .data_lines_oe_o(oe));
  nvram_model nvram_model_inst (.clk_i, .cs_n_i(cs_n), .we_n_i(we_n),
    .gate_n_i(gate_n), .nv_n_i(nv_n), .addr_i(addr_o), .din_i(bus),
    .dout_o(dev_q));
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one request, held until taken, then wait for done
  task automatic do_op(input logic [1:0] op, input logic [10:0] a,
    input logic [7:0] d);
    int n;
    @(negedge clk_i);
    {req_valid_i, req_op_i, req_addr_i, req_wdata_i} = {1'h1, op, a, d};
    // ready is settled at the falling edge; the next rising edge takes it
    for (n = 0; req_ready_o !== 1'h1 && n < 99; n++) @(negedge clk_i);
    @(posedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'h0;
    for (n = 0; done_o !== 1'h1 && n < 99; n++) @(negedge clk_i);
    check("done", {7'h00, done_o}, 8'h01);
  endtask
  task automatic test_power_up;
    repeat (5) @(negedge clk_i);
    check("ready", {7'h00, req_ready_o}, 8'h00);
    check("pins", {3'h0, oe, cs_n, we_n, gate_n, nv_n}, 8'h0F);
    $display("test power_up done");
  endtask
  task automatic test_read_write;
    do_op(nvram_host_pkg::OP_WRITE, 11'h7FF, 8'hA5);
    do_op(nvram_host_pkg::OP_WRITE, 11'h000, 8'h3C);
    do_op(nvram_host_pkg::OP_READ, 11'h7FF, 8'h00);
    check("rdata", rdata_o, 8'hA5);
    do_op(nvram_host_pkg::OP_READ, 11'h000, 8'h00);
    check("rdata", rdata_o, 8'h3C);
    $display("test read_write done");
  endtask
  task automatic test_save_reload;
    do_op(nvram_host_pkg::OP_WRITE, 11'h123, 8'h5A);
    do_op(nvram_host_pkg::OP_SAVE, 11'h000, 8'h00);
    do_op(nvram_host_pkg::OP_WRITE, 11'h123, 8'hC3);
    do_op(nvram_host_pkg::OP_READ, 11'h123, 8'h00);
    check("rdata", rdata_o, 8'hC3);
    do_op(nvram_host_pkg::OP_RELOAD, 11'h000, 8'h00);
    do_op(nvram_host_pkg::OP_READ, 11'h123, 8'h00);
    check("rdata", rdata_o, 8'h5A);
    $display("test save_reload done");
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1;
    test_power_up;
    test_read_write;
    test_save_reload;
    give_verdict;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict;
    end
  end
endmodule
